// File: hw/adc_out_consts.svh
// Offsets, field positions, reset values and timing counts of the output port block
`ifndef ADC_OUT_CONSTS_SVH
`define ADC_OUT_CONSTS_SVH
// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define IDX_LOAD_DRIVE 8'h63
`define IDX_CLK_PHASE 8'h64
`define IDX_PORT_CTRL 8'h80
`define IDX_PATTERN_A 8'h81
`define IDX_PATTERN_B 8'h82
`define IDX_PORT_STATUS 8'h83
// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define LOAD_EN_BIT 3
`define IMODE_LSB 0
`define PH_EN_BIT 7
`define PH_SEL_LSB 4
`define CTRL_MODE_LSB 0
`define CTRL_RATIO_LSB 4
`define CTRL_FILT_DEF_BIT 8
// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_LOAD_DRIVE 8'h01
`define RST_CLK_PHASE 8'h03
`define RST_PORT_CTRL 9'h110
`define RST_PATTERN 12'h000
// ------------------------------------------------------------------
// Timing counts in sample clock cycles and the decimation ratio limit of the phase code
// ------------------------------------------------------------------
`define OVR_STEP_CYCLES 524288
`define WCK_STEP_CYCLES 262144
`define MIN_PHASE_RATIO 3'h2
`endif

// File: hw/adc_out_pkg.sv
// Types shared by the output port block
`default_nettype none
package adc_out_pkg;
    // Test pattern selection of the output port
    typedef enum logic [1:0] {
        mode_normal,
        mode_counting,
        mode_custom,
        mode_spare
    } test_mode_e;
    // Register state of the top module
    typedef struct packed {
        logic [7:0] load_drive;
        logic [7:0] clk_phase;
        logic [8:0] port_ctrl;
        logic [11:0] pattern_a;
        logic [11:0] pattern_b;
        logic [31:0] rdata;
        logic [19:0] ovr_cnt;
        logic [19:0] wck_cnt;
        logic ovr_bit;
        logic wck_bit;
        logic pat_sel;
        logic [11:0] q_out;
    } port_state_s;
    // State of the output clock phase generator
    typedef struct packed {
        logic [2:0] step;
        logic clk_out;
    } phase_state_s;
endpackage : adc_out_pkg
`default_nettype wire

// File: hw/phase_clock_gen.sv
// Output data clock with eight selectable 45 degree phase steps
`include "adc_out_consts.svh"
`default_nettype none
module phase_clock_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Applied phase code, 0 is the reference phase
    input wire logic [2:0] phase_code,
    // Data clock towards the capture logic
    output logic data_clock_out
);
    import adc_out_pkg::*;
    phase_state_s s_q;
    phase_state_s s_d;
    logic [2:0] lag;

    // ------------------------------------------------------------------
    // Eight-step period, each code delays the clock by one step
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.step = s_q.step + 3'h1;
        lag = s_q.step - phase_code; // RULE5 RULE8
        s_d.clk_out = ~lag[2];
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign data_clock_out = s_q.clk_out;

    // Clock rises exactly phase_code steps after the reference rise; a code change
    // one cycle earlier may give one early rise, so the code must stand for two cycles
    a_phase_rise: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        $rose(s_q.clk_out) && $stable(phase_code) && $past(phase_code) == $past(phase_code, 2)
        |-> s_q.step == phase_code + 3'h1)
        else $error("data clock rise not at selected phase");
endmodule : phase_clock_gen
`default_nettype wire

// File: hw/adc_output_port_config.sv
// Output port configuration registers, test patterns and data clock phase
//
// Behaviour
// RULE1: Counting pattern toggles the overrange bit every 2^19 cycles and word clock every 2^18.
// RULE2: Custom pattern drives A and B on twelve bits, bit 11 on overrange and bit 10 on word clock.
// RULE3: The termination-enable bit switches the LVDS load on when set and is clear after reset.
// RULE4: Software must not write the reserved driver current codes since the drive is undefined.
// RULE5: The three-bit phase code delays the data clock by code times 45 degrees.
// RULE6: The phase code acts only when the decimation ratio is above two.
// RULE7: With default filter settings only the odd phase codes are used.
// RULE8: Every phase shift is measured from code zero, the reset value of the field.
// RULE9: The phase-delay enable bit gates the shift; when clear the default phase is used.
`include "adc_out_consts.svh"
`default_nettype none
module adc_output_port_config #(
    parameter int OVR_STEP = `OVR_STEP_CYCLES,
    parameter int WCK_STEP = `WCK_STEP_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter sample path
    input wire logic [11:0] sample_data,
    input wire logic sample_overrange,
    input wire logic sample_word_clock,
    // Output port towards capture logic
    output logic [9:0] q_data,
    output logic overrange_flag,
    output logic word_clock_out,
    output logic data_clock_out,
    // Driver configuration
    output logic termination_enable,
    output logic [2:0] driver_current_select
);
    import adc_out_pkg::*;
    port_state_s s_q;
    port_state_s s_d;
    logic wr_en;
    logic rd_setup;
    logic [7:0] idx;
    logic [2:0] phase_sel;
    logic [2:0] applied_phase;
    logic [2:0] decim_ratio;
    logic phase_delay_enable;
    logic filter_default;
    test_mode_e mode;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Unaligned or out-of-map addresses answer with an error
    function automatic logic mapped(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        mapped = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
            (i == `IDX_LOAD_DRIVE || i == `IDX_CLK_PHASE || i == `IDX_PORT_CTRL ||
             i == `IDX_PATTERN_A || i == `IDX_PATTERN_B || i == `IDX_PORT_STATUS);
    endfunction : mapped

    assign idx = paddr[9:2];
    assign wr_en = psel && penable && pwrite && mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);

    // Field views of the stored registers
    assign phase_sel = s_q.clk_phase[`PH_SEL_LSB +: 3];
    assign phase_delay_enable = s_q.clk_phase[`PH_EN_BIT];
    assign decim_ratio = s_q.port_ctrl[`CTRL_RATIO_LSB +: 3];
    assign filter_default = s_q.port_ctrl[`CTRL_FILT_DEF_BIT];
    assign mode = test_mode_e'(s_q.port_ctrl[`CTRL_MODE_LSB +: 2]);

    // ------------------------------------------------------------------
    // Applied phase code
    // ------------------------------------------------------------------
    // Nonzero even codes move up to the next odd step under the default filter,
    // so a forbidden code still yields a defined clock
    always_comb begin
        applied_phase = 3'h0; // RULE8
        if (phase_delay_enable && decim_ratio > `MIN_PHASE_RATIO) begin // RULE6 RULE9
            applied_phase = phase_sel;
            if (filter_default && phase_sel != 3'h0) begin
                applied_phase = phase_sel | 3'h1; // RULE7
            end
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Register writes at the access edge
        if (wr_en) begin
            case (idx)
                `IDX_LOAD_DRIVE: s_d.load_drive = pwdata[7:0];
                `IDX_CLK_PHASE: s_d.clk_phase = pwdata[7:0];
                `IDX_PORT_CTRL: s_d.port_ctrl = pwdata[8:0];
                `IDX_PATTERN_A: s_d.pattern_a = pwdata[11:0];
                `IDX_PATTERN_B: s_d.pattern_b = pwdata[11:0];
                default: s_d.port_ctrl = s_q.port_ctrl;
            endcase
        end
        // Read data captured in the setup cycle, so it comes from a flop;
        // refused addresses, unaligned ones too, read as zero
        if (rd_setup) begin
            case (mapped(paddr) ? idx : 8'h00)
                `IDX_LOAD_DRIVE: s_d.rdata = {24'h0, s_q.load_drive};
                `IDX_CLK_PHASE: s_d.rdata = {24'h0, s_q.clk_phase};
                `IDX_PORT_CTRL: s_d.rdata = {23'h0, s_q.port_ctrl};
                `IDX_PATTERN_A: s_d.rdata = {20'h0, s_q.pattern_a};
                `IDX_PATTERN_B: s_d.rdata = {20'h0, s_q.pattern_b};
                `IDX_PORT_STATUS: s_d.rdata = {27'h0, applied_phase, s_q.wck_bit, s_q.ovr_bit};
                default: s_d.rdata = 32'h0;
            endcase
        end
        // Counting pattern step counters run only in counting mode
        if (mode == mode_counting) begin
            s_d.ovr_cnt = s_q.ovr_cnt + 20'h1;
            s_d.wck_cnt = s_q.wck_cnt + 20'h1;
            if (s_q.ovr_cnt == 20'(OVR_STEP - 1)) begin // RULE1
                s_d.ovr_cnt = 20'h0;
                s_d.ovr_bit = ~s_q.ovr_bit;
            end
            if (s_q.wck_cnt == 20'(WCK_STEP - 1)) begin // RULE1
                s_d.wck_cnt = 20'h0;
                s_d.wck_bit = ~s_q.wck_bit;
            end
        end else begin
            s_d.ovr_cnt = 20'h0;
            s_d.wck_cnt = 20'h0;
            s_d.ovr_bit = 1'b0;
            s_d.wck_bit = 1'b0;
        end
        // Output word selection
        s_d.pat_sel = (mode == mode_custom) ? ~s_q.pat_sel : 1'b0;
        case (mode)
            mode_counting: s_d.q_out = {s_d.ovr_bit, s_d.wck_bit, sample_data[9:0]};
            mode_custom: s_d.q_out = s_q.pat_sel ? s_q.pattern_b : s_q.pattern_a; // RULE2
            mode_normal: s_d.q_out = {sample_overrange, sample_word_clock, sample_data[9:0]};
            default: s_d.q_out = 12'h000;
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.load_drive <= `RST_LOAD_DRIVE; // RULE3
            s_q.clk_phase <= `RST_CLK_PHASE; // RULE8
            s_q.port_ctrl <= `RST_PORT_CTRL;
            s_q.pattern_a <= `RST_PATTERN;
            s_q.pattern_b <= `RST_PATTERN;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = s_q.rdata;
    assign q_data = s_q.q_out[9:0];
    assign overrange_flag = s_q.q_out[11]; // RULE2
    assign word_clock_out = s_q.q_out[10]; // RULE2
    assign termination_enable = s_q.load_drive[`LOAD_EN_BIT]; // RULE3
    // Reserved current codes pass through untouched; drive is then undefined
    assign driver_current_select = s_q.load_drive[`IMODE_LSB +: 3]; // RULE4

    phase_clock_gen u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .phase_code(applied_phase),
        .data_clock_out(data_clock_out)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_ovr_step: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        mode == mode_counting && $past(mode) == mode_counting &&
        s_q.ovr_cnt == 20'h0 && $past(s_q.ovr_cnt) != 20'h0 |-> s_q.ovr_bit != $past(s_q.ovr_bit))
        else $error("overrange count bit did not advance");
    a_wck_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        mode == mode_counting && $past(mode) == mode_counting &&
        s_q.wck_cnt != 20'h0 |-> s_q.wck_bit == $past(s_q.wck_bit))
        else $error("word clock count bit moved between steps");
    a_custom_map: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        mode == mode_custom && $stable(mode) && $stable(s_q.pattern_a) && $stable(s_q.pattern_b)
        ##1 $stable(mode) && $stable(s_q.pattern_a) && $stable(s_q.pattern_b)
        |-> {overrange_flag, word_clock_out, q_data} ==
        ($past(s_q.pat_sel) ? s_q.pattern_b : s_q.pattern_a))
        else $error("custom pattern not on output bits");
    a_custom_alt: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        mode == mode_custom ##1 mode == mode_custom |-> s_q.pat_sel != $past(s_q.pat_sel))
        else $error("custom patterns do not alternate");
    a_term_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        wr_en && idx == `IDX_LOAD_DRIVE |=> termination_enable == $past(pwdata[`LOAD_EN_BIT]))
        else $error("termination enable not taken from write");
    a_ratio_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        decim_ratio <= `MIN_PHASE_RATIO |-> applied_phase == 3'h0)
        else $error("phase applied at low decimation ratio");
    a_odd_only: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        filter_default && applied_phase != 3'h0 |-> applied_phase[0])
        else $error("even phase code used with default filter");
    a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        !phase_delay_enable |-> applied_phase == 3'h0 ##1 1'b1)
        else $error("phase shift without enable");
    a_phase_pass: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        phase_delay_enable && decim_ratio > `MIN_PHASE_RATIO && !filter_default
        |-> applied_phase == phase_sel)
        else $error("phase code not passed to clock");
endmodule : adc_output_port_config
`default_nettype wire

// File: testbench/capture_model.sv
// Capture-side model that timestamps the rises of the port's data clock
`default_nettype none
module capture_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data clock from the output port
    input wire logic data_clock_out,
    // Slot of the last rise within the eight-cycle frame
    output logic [2:0] rise_slot
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] slot_q;
    logic prev_q;
    // Free slot count; the rise is seen one sample late for every code, so offsets cancel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_q <= 3'h0;
            prev_q <= 1'b0;
            rise_slot <= 3'h0;
        end else begin
            slot_q <= slot_q + 3'h1;
            prev_q <= data_clock_out;
            if (data_clock_out && !prev_q) begin
                rise_slot <= slot_q;
            end
        end
    end
endmodule : capture_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench of the output port configuration block
`include "adc_out_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Short counting steps keep the run brief
    localparam int OVR_N = 16;
    localparam int WCK_N = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    logic [11:0] sample_data = 12'h000;
    logic sample_overrange = 1'b0, sample_word_clock = 1'b0;
    logic [9:0] q_data;
    logic overrange_flag, word_clock_out, data_clock_out, termination_enable;
    logic [2:0] driver_current_select, rise_slot, ref_slot;
    int error_cnt = 0, check_count = 0, n;
    typedef struct packed {logic [8:0] ctrl; logic [7:0] ph; logic [2:0] exp;} row_s;
    // Control word, phase register, applied phase
    row_s rows [9] = '{'{9'h030, 8'ha3, 3'h2}, '{9'h130, 8'ha3, 3'h3}, '{9'h130, 8'hc3, 3'h5},
        '{9'h130, 8'hf3, 3'h7}, '{9'h130, 8'h83, 3'h0}, '{9'h020, 8'hf3, 3'h0},
        '{9'h070, 8'hd3, 3'h5}, '{9'h030, 8'h73, 3'h0}, '{9'h030, 8'h93, 3'h1}};

    adc_output_port_config #(.OVR_STEP(OVR_N), .WCK_STEP(WCK_N)) i_dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sample_data, .sample_overrange, .sample_word_clock, .q_data, .overrange_flag,
        .word_clock_out, .data_clock_out, .termination_enable, .driver_current_select);
    capture_model i_cap (.pclk, .presetn, .data_clock_out, .rise_slot);

    // 20 MHz clock
    always #25 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: a slave that never answers is caught by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [11:0] word();
        return {overrange_flag, word_clock_out, q_data};
    endfunction : word
    task automatic tick();
        @(posedge pclk);
        #1;
    endtask : tick
    // Let the data clock settle, then compare measured and reported phase
    task automatic phase_check(input logic [2:0] exp);
        repeat (24) tick();
        check("phase rise", 32'(3'(rise_slot - ref_slot)), 32'(exp));
        apb(1'b0, `IDX_PORT_STATUS, 32'h0);
        check("phase status", 32'(rd[4:2]), 32'(exp));
    endtask : phase_check
    // Waits for one toggle, then counts cycles to the next
    task automatic gap(input logic sel, output int cnt);
        logic v;
        repeat (2) begin
            v = sel ? overrange_flag : word_clock_out;
            cnt = 0;
            while ((sel ? overrange_flag : word_clock_out) === v && cnt < 40) begin
                tick();
                cnt++;
            end
        end
    endtask : gap
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        tick();
        check("load after reset", 32'(termination_enable), 32'h0);
        check("current after reset", 32'(driver_current_select), 32'h1);
        apb(1'b0, `IDX_CLK_PHASE, 32'h0);
        check("phase reset", rd, 32'h03);
        sample_data <= 12'hfa5;
        sample_overrange <= 1'b1;
        repeat (2) tick();
        check("normal word", 32'(word()), 32'h00000ba5);
        ref_slot = rise_slot;
        foreach (rows[k]) begin
            apb(1'b1, `IDX_PORT_CTRL, {23'h0, rows[k].ctrl});
            apb(1'b1, `IDX_CLK_PHASE, {24'h0, rows[k].ph});
            phase_check(rows[k].exp);
        end
        // Every phase code with the filter away from default
        apb(1'b1, `IDX_PORT_CTRL, 32'h030);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `IDX_CLK_PHASE, {24'h0, 1'b1, c[2:0], 4'h3});
            phase_check(c[2:0]);
        end
        // Only the documented current codes are written
        apb(1'b1, `IDX_LOAD_DRIVE, 32'h0f);
        check("write resp", 32'(er), 32'h0);
        apb(1'b0, `IDX_LOAD_DRIVE, 32'h0);
        check("load readback", rd, 32'h0f);
        check("load on", 32'({termination_enable, driver_current_select}), 32'hf);
        apb(1'b1, `IDX_LOAD_DRIVE, 32'h03);
        tick();
        check("load off", 32'({termination_enable, driver_current_select}), 32'h3);
        // Unmapped place: refused, reads zero
        apb(1'b1, 8'h00, 32'hff);
        check("unmapped wr err", 32'(er), 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        check("unmapped rd", {rd[30:0], er}, 32'h1);
        // Custom patterns alternate A then B
        apb(1'b1, `IDX_PATTERN_A, 32'habc);
        apb(1'b1, `IDX_PATTERN_B, 32'h5a3);
        apb(1'b1, `IDX_PORT_CTRL, 32'h112);
        n = 0;
        while (word() !== 12'habc && n < 6) begin
            tick();
            n++;
        end
        check("custom A", 32'(word()), 32'habc);
        tick();
        check("custom B", 32'(word()), 32'h5a3);
        tick();
        check("custom A again", 32'(word()), 32'habc);
        apb(1'b1, `IDX_PORT_CTRL, 32'h113);
        repeat (2) tick();
        check("zero mode", 32'(word()), 32'h0);
        // Counting pattern step lengths
        apb(1'b1, `IDX_PORT_CTRL, 32'h111);
        gap(1'b0, n);
        check("word clock gap", n, WCK_N);
        gap(1'b1, n);
        check("overrange gap", n, OVR_N);
        // Second reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `IDX_CLK_PHASE, 32'h0);
        check("phase re-reset", rd, 32'h03);
        apb(1'b0, `IDX_PORT_CTRL, 32'h0);
        check("ctrl re-reset", rd, 32'h110);
        check("load re-reset", 32'(termination_enable), 32'h0);
        check("current re-reset", 32'(driver_current_select), 32'h1);
        print_verdict();
    end

    // Watchdog well beyond the expected run of about 650 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
